/* File: design/ncps_dev.sv */
// What this block does
// RULE1 - Confirm 15h starts cached program
// RULE2 - 15h moves cache to buffer, busy
// RULE3 - Later 15h waits prior page first
// RULE4 - 10h ends; ready after last page
// RULE5 - Host restarts sequence on block change
// RULE6 - Status bit one current, two previous
// RULE7 - Bits six, seven buffer and cache ready
// RULE8 - Idle window reports page two, page one
// RULE9 - Program starts on confirm strobe; the code starts it when the cache-to-buffer transfer count ends
// RULE10 - Program/verify loop, fail at limit
// RULE11 - Host repeats 64 pages, ends 81-10
// RULE12 - 71h shows multi-page result
// RULE13 - 71h byte district bits, protect bit
// RULE14 - 71h bit one ORs district results
// RULE15 - Two districts, odd/even block split
// RULE16 - One block per district, same page
// RULE17 - 80, addr, data, 11, 81, confirm
// RULE18 - Only sequence codes, status, reset
// RULE19 - Host waits ready before next phase
// Purpose: Flash end: cached and two-district program sequencer
// Assumes: Host keeps the command order; inputs synchronous
// Notes:   Array modelled by a fail-injection input only
`timescale 1ns/100ps
module ncps_dev (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  ncps_if.dev       port,
  input  wire logic [1:0] fail_inject, // Per-district forced fail
  output logic      prog_active        // Array is programming
);
  // Sequencer states for the command decoder
  typedef enum logic [2:0] {
    CS_IDLE, CS_ADDR, CS_DATA, CS_WAIT2, CS_STAT
  } ncps_cmd_e;
  // Array side states
  typedef enum logic [2:0] {
    AS_IDLE, AS_PULSE, AS_VERIFY
  } ncps_arr_e;

  ncps_cmd_e   cmd_ff;         // Decoder state
  ncps_arr_e   arr_ff;         // Array state
  logic [2:0]  acnt_ff;        // Address byte count
  logic [1:0]  dist_ff;        // Districts loaded this step
  logic [1:0]  cache_dist_ff;  // Districts in the cache
  logic [1:0]  pb_dist_ff;     // Districts in page buffer
  logic        cache_full_ff;  // Cache holds a waiting page
  logic        final_ff;       // Last page handed over
  logic [7:0]  xfer_ff;        // Transfer busy counter
  logic [7:0]  tcnt_ff;        // Pulse / verify counter
  logic [3:0]  loop_ff;        // Loop counter
  logic [1:0]  cur_ff;         // Current result per district
  logic [1:0]  prev_ff;        // Previous result per district
  logic        stat71_ff;      // Status flavour selected
  logic [7:0]  sbyte;          // Status byte to drive
  logic [7:0]  dout_ff;        // Registered output byte
  logic        dout_oe_ff;     // Registered output enable
  logic        pb_busy;        // Page buffer busy
  logic        dc_busy;        // Cache busy

  wire cmd_stb  = port.we_p & port.cle;
  wire addr_stb = port.we_p & port.ale;
  wire confirm  = cmd_stb & ((port.h_io == ncps_pkg::CMD_CACHE_CONF) |
                             (port.h_io == ncps_pkg::CMD_FINAL_CONF));

  // Cache busy while moving or waiting for the buffer
  assign dc_busy = cache_full_ff | (xfer_ff != 8'h00);
  assign pb_busy = (arr_ff != AS_IDLE); // see RULE7
  assign prog_active = (arr_ff != AS_IDLE);
  // Pin is cache ready until final, then cache and buffer ready
  assign port.ready_busy_pin = final_ff ? ~(pb_busy | dc_busy)
                                        : ~dc_busy; // see RULE4

  // Command decoder
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_ff    <= CS_IDLE;
      acnt_ff   <= 3'h0;
      dist_ff   <= 2'h0;
      stat71_ff <= 1'b0;
    end
    else if (cmd_stb)
    begin
      case (port.h_io)
        ncps_pkg::CMD_DATA_IN:   // Fresh step, first plane
        begin
          cmd_ff   <= CS_ADDR;
          acnt_ff  <= 3'h0;
          dist_ff  <= 2'h0;
        end
        ncps_pkg::CMD_PLANE_SW:  // Wait for second plane, see RULE17
          cmd_ff <= CS_WAIT2;
        ncps_pkg::CMD_DATA_IN2:
        begin
          cmd_ff   <= CS_ADDR;
          acnt_ff  <= 3'h0;
        end
        ncps_pkg::CMD_CACHE_CONF, ncps_pkg::CMD_FINAL_CONF:
        begin
          cmd_ff   <= CS_IDLE;
        end
        ncps_pkg::CMD_STATUS:
        begin
          cmd_ff    <= CS_STAT;
          stat71_ff <= 1'b0;
        end
        ncps_pkg::CMD_MSTATUS:
        begin
          cmd_ff    <= CS_STAT;
          stat71_ff <= 1'b1;      // see RULE12
        end
        default:                  // Reset and unknown codes
        begin
          cmd_ff   <= CS_IDLE;
          dist_ff  <= 2'h0;
        end
      endcase
    end
    else if (addr_stb && cmd_ff == CS_ADDR)
    begin
      // Third address byte bit 6 is the low block bit
      if (acnt_ff == 3'h2)
        dist_ff <= dist_ff |   // Odd block is district one, see RULE15
                   (port.h_io[ncps_pkg::PAGE_BITS] ? 2'h2 : 2'h1);
      acnt_ff <= acnt_ff + 3'h1;
      if (acnt_ff == 3'(ncps_pkg::ADDR_CYCLES - 1))
        cmd_ff <= CS_DATA;
    end
  end

  // Cache and page buffer hand-off
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cache_full_ff <= 1'b0;
      cache_dist_ff <= 2'h0;
      pb_dist_ff    <= 2'h0;
      xfer_ff       <= 8'h00;
      final_ff      <= 1'b0;
    end
    else if (cmd_stb && port.h_io == ncps_pkg::CMD_RESET)
    begin
      cache_full_ff <= 1'b0;
      xfer_ff       <= 8'h00;
      final_ff      <= 1'b0;
    end
    else if (confirm)
    begin
      // Either confirm fills the cache, see RULE1
      cache_full_ff <= 1'b1;
      cache_dist_ff <= dist_ff;
      final_ff      <= (port.h_io == ncps_pkg::CMD_FINAL_CONF);
    end
    else if (cache_full_ff && arr_ff == AS_IDLE && xfer_ff == 8'h00)
    begin
      // Buffer free: start moving cache over, see RULE3
      cache_full_ff <= 1'b0;
      pb_dist_ff    <= cache_dist_ff;
      xfer_ff       <= ncps_pkg::XFER_CYC;  // see RULE2
    end
    else if (xfer_ff != 8'h00)
      xfer_ff <= xfer_ff - 8'h01;
    else if (cmd_stb && port.h_io == ncps_pkg::CMD_DATA_IN)
      final_ff <= 1'b0;
  end

  // Program and verify loop
  wire xfer_done = (xfer_ff == 8'h01);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arr_ff  <= AS_IDLE;
      tcnt_ff <= 8'h00;
      loop_ff <= 4'h0;
      cur_ff  <= 2'h0;
      prev_ff <= 2'h0;
    end
    else if (cmd_stb && port.h_io == ncps_pkg::CMD_RESET)
      arr_ff <= AS_IDLE;
    else
    begin
      case (arr_ff)
        AS_IDLE:
          if (xfer_done)                   // see RULE9
          begin
            arr_ff  <= AS_PULSE;
            tcnt_ff <= ncps_pkg::PULSE_CYC;
            loop_ff <= 4'h1;
            prev_ff <= cur_ff;              // see RULE8
          end
        AS_PULSE:
          if (tcnt_ff == 8'h01)
          begin
            arr_ff  <= AS_VERIFY;
            tcnt_ff <= ncps_pkg::VERIFY_CYC;
          end
          else
            tcnt_ff <= tcnt_ff - 8'h01;
        AS_VERIFY:
          if (tcnt_ff != 8'h01)
            tcnt_ff <= tcnt_ff - 8'h01;
          else if ((fail_inject & pb_dist_ff) == 2'h0)
          begin
            arr_ff <= AS_IDLE;              // Verified pass
            cur_ff <= 2'h0;
          end
          else if (loop_ff == ncps_pkg::MAX_LOOPS)
          begin
            arr_ff <= AS_IDLE;              // see RULE10
            cur_ff <= fail_inject & pb_dist_ff;
          end
          else
          begin
            arr_ff  <= AS_PULSE;            // Retry pulse
            tcnt_ff <= ncps_pkg::PULSE_CYC;
            loop_ff <= loop_ff + 4'h1;
          end
        default:
          arr_ff <= AS_IDLE;
      endcase
    end
  end

  // Status byte assembly
  always_comb
  begin
    sbyte = 8'h00;
    sbyte[ncps_pkg::ST_PB_RDY] = ~pb_busy;   // see RULE7
    sbyte[ncps_pkg::ST_DC_RDY] = ~dc_busy;
    sbyte[ncps_pkg::ST_WP_N]   = port.wp_n;   // see RULE13
    if (stat71_ff)
    begin
      sbyte[ncps_pkg::ST_D0_P] = cur_ff[0];
      sbyte[ncps_pkg::ST_D1_P] = cur_ff[1];
      sbyte[ncps_pkg::ST_D0_S] = prev_ff[0];
      sbyte[ncps_pkg::ST_D1_S] = prev_ff[1];
      sbyte[ncps_pkg::ST_CUR] = cur_ff[0] | cur_ff[1]; // see RULE14
    end
    else
    begin
      sbyte[ncps_pkg::ST_CUR]  = |cur_ff;     // see RULE6
      sbyte[ncps_pkg::ST_PREV] = |prev_ff;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_ff    <= 8'h00;
      dout_oe_ff <= 1'b0;
    end
    else
    begin
      dout_oe_ff <= port.re_p && cmd_ff == CS_STAT;
      if (port.re_p)
        dout_ff <= sbyte;
    end
  end

  assign port.d_io    = dout_ff;
  assign port.d_io_oe = dout_oe_ff;
endmodule : ncps_dev

/* File: design/ncps_host.sv */
// Purpose: Controller end: runs cached two-district program runs
// Assumes: Register port of one-cycle strobes, start held two cycles; read data next cycle
// Notes:   Data bytes are a counting pattern
`timescale 1ns/100ps
module ncps_host (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  ncps_if.host             port,
  input  wire logic [3:0]  reg_addr,   // Register index
  input  wire logic [31:0] reg_wdata,  // Write data
  input  wire logic        reg_wr,     // Write strobe
  input  wire logic        reg_rd,     // Read strobe
  output logic      [31:0] reg_rdata,  // Read data, next cycle
  output logic             irq         // Level interrupt
);
  typedef enum logic [3:0] {
    HS_IDLE, HS_C1, HS_A1, HS_D1, HS_SW, HS_C2, HS_A2, HS_D2,
    HS_CONF, HS_WAIT, HS_STCMD, HS_STRD, HS_STCAP
  } ncps_hst_e;

  ncps_hst_e   st_ff;        // Sequence state
  logic [2:0]  cnt_ff;       // Byte counter
  logic [6:0]  page_ff;      // Page in block
  logic [6:0]  npages_ff;    // Pages per run
  logic [11:0] block_ff;     // Even block of the pair
  logic [7:0]  result_ff;    // Last status byte
  logic [1:0]  irq_ff;       // Sticky: done, fail
  logic [1:0]  mask_ff;      // Interrupt mask
  logic        ph_ff;        // Cycle phase: strobe every other
  logic [7:0]  io_ff;        // Byte driven
  logic        cle_ff, ale_ff, we_ff, re_ff, oe_ff;
  logic [31:0] rdata_ff;

  wire last_pg = (page_ff == npages_ff - 7'h1);
  wire [7:0] conf = last_pg ? ncps_pkg::CMD_FINAL_CONF
                            : ncps_pkg::CMD_CACHE_CONF;
  // Address byte n: 0,1 column, 2 page+two block lsbs, 3,4 block high
  function automatic logic [7:0] abyte(input logic [2:0] n,
                                       input logic d);
    logic [11:0] b;
    b = block_ff | {11'h0, d};   // see RULE16
    case (n)
      3'h2:    abyte = {b[1:0], page_ff[5:0]};
      3'h3:    abyte = b[9:2];
      3'h4:    abyte = {6'h0, b[11:10]};
      default: abyte = 8'h00;
    endcase
  endfunction : abyte

  // Sequence engine, strobes on alternate cycles
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff     <= HS_IDLE;
      cnt_ff    <= 3'h0;
      page_ff   <= 7'h0;
      ph_ff     <= 1'b0;
      io_ff     <= 8'h00;
      oe_ff     <= 1'b0;
      cle_ff    <= 1'b0;
      ale_ff    <= 1'b0;
      we_ff     <= 1'b0;
      re_ff     <= 1'b0;
      result_ff <= 8'h00;
    end
    else
    begin
      we_ff <= 1'b0;
      re_ff <= 1'b0;
      ph_ff <= ~ph_ff;
      if (ph_ff)
      begin
        case (st_ff)
          HS_IDLE:
            if (reg_wr && reg_addr == ncps_pkg::REG_CTRL && reg_wdata[0])
            begin
              st_ff   <= HS_C1;   // New block pair restarts, see RULE5
              page_ff <= 7'h0;
            end
          HS_C1:
            if (port.ready_busy_pin)   // see RULE19
            begin
              {cle_ff, ale_ff, we_ff, oe_ff} <= 4'b1011;
              io_ff  <= ncps_pkg::CMD_DATA_IN;  // see RULE17
              cnt_ff <= 3'h0;
              st_ff  <= HS_A1;
            end
          HS_A1, HS_A2:
          begin
            {cle_ff, ale_ff, we_ff} <= 3'b011;
            io_ff  <= abyte(cnt_ff, st_ff == HS_A2);
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'(ncps_pkg::ADDR_CYCLES - 1))
            begin
              cnt_ff <= 3'h0;
              st_ff  <= (st_ff == HS_A1) ? HS_D1 : HS_D2;
            end
          end
          HS_D1, HS_D2:
          begin
            {cle_ff, ale_ff, we_ff} <= 3'b001;
            io_ff  <= {page_ff[4:0], cnt_ff};
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'(ncps_pkg::DATA_BYTES - 1))
              st_ff <= (st_ff == HS_D1) ? HS_SW : HS_CONF;
          end
          HS_SW:
          begin
            {cle_ff, ale_ff, we_ff} <= 3'b101;
            io_ff <= ncps_pkg::CMD_PLANE_SW;
            st_ff <= HS_C2;
          end
          HS_C2:
          begin
            {cle_ff, ale_ff, we_ff} <= 3'b101;
            io_ff  <= ncps_pkg::CMD_DATA_IN2;   // see RULE11
            cnt_ff <= 3'h0;
            st_ff  <= HS_A2;
          end
          HS_CONF:
          begin
            {cle_ff, ale_ff, we_ff} <= 3'b101;
            io_ff <= conf;                       // see RULE4
            st_ff <= HS_WAIT;
          end
          HS_WAIT:   // Let busy appear, wait for the ready pin, then read 71h once, see RULE12
            st_ff <= HS_STCMD;
          HS_STCMD:
            if (port.ready_busy_pin)
            begin
              {cle_ff, ale_ff, we_ff} <= 3'b101;
              io_ff <= ncps_pkg::CMD_MSTATUS;    // see RULE18
              st_ff <= HS_STRD;
            end
          HS_STRD:
          begin
            {cle_ff, ale_ff, oe_ff, re_ff} <= 4'b0001;
            st_ff <= HS_STCAP;
          end
          HS_STCAP:
          begin
            result_ff <= port.d_io;
            if (last_pg)
              st_ff <= HS_IDLE;
            else
            begin
              page_ff <= page_ff + 7'h1;
              st_ff   <= HS_C1;
            end
          end
          default:
            st_ff <= HS_IDLE;
        endcase
      end
    end
  end

  // Run settings
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      npages_ff <= 7'(ncps_pkg::PAGES_PER_BLOCK);
      block_ff  <= 12'h000;
      mask_ff   <= 2'h0;
    end
    else if (reg_wr && st_ff == HS_IDLE)
    begin
      if (reg_addr == ncps_pkg::REG_PAGES)
        npages_ff <= reg_wdata[6:0];
      if (reg_addr == ncps_pkg::REG_BLOCK)
        block_ff <= {reg_wdata[11:1], 1'b0};
      if (reg_addr == ncps_pkg::REG_MASK)
        mask_ff <= reg_wdata[1:0];
    end
    else if (reg_wr && reg_addr == ncps_pkg::REG_MASK)
      mask_ff <= reg_wdata[1:0];
  end

  // Sticky events; a set beats a clear in the same cycle
  wire run_end = ph_ff && st_ff == HS_STCAP && last_pg;
  wire [1:0] ev = {run_end & port.d_io[0], run_end};
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_ff <= 2'h0;
    else
    begin
      if (reg_wr && reg_addr == ncps_pkg::REG_IRQ)
        irq_ff <= (irq_ff & ~reg_wdata[1:0]) | ev;
      else
        irq_ff <= irq_ff | ev;
    end
  end
  assign irq = |(irq_ff & mask_ff);

  // Register reads, data one cycle later
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= ncps_pkg::RST_ZERO;
    else if (reg_rd)
    begin
      case (reg_addr)
        ncps_pkg::REG_STATUS: rdata_ff <= {16'h0, 1'b0, page_ff,
                                           7'h0, st_ff != HS_IDLE};
        ncps_pkg::REG_RESULT: rdata_ff <= {24'h0, result_ff};
        ncps_pkg::REG_IRQ:    rdata_ff <= {30'h0, irq_ff};
        ncps_pkg::REG_MASK:   rdata_ff <= {30'h0, mask_ff};
        ncps_pkg::REG_PAGES:  rdata_ff <= {25'h0, npages_ff};
        ncps_pkg::REG_BLOCK:  rdata_ff <= {20'h0, block_ff};
        default:              rdata_ff <= ncps_pkg::RST_ZERO;
      endcase
    end
    else
      rdata_ff <= ncps_pkg::RST_ZERO;
  end
  assign reg_rdata = rdata_ff;

  assign port.cle     = cle_ff;
  assign port.ale     = ale_ff;
  assign port.we_p    = we_ff;
  assign port.re_p    = re_ff;
  assign port.h_io    = io_ff;
  assign port.h_io_oe = oe_ff;
  assign port.wp_n    = 1'b1;
endmodule : ncps_host

/* File: design/ncps_if.sv */
// Purpose: Byte port between flash controller and flash sequencer
// Assumes: Same clock both ends; write strobe is a one-cycle pulse
// Notes:   io bus split into out/enable per end
`timescale 1ns/100ps
interface ncps_if;
  logic       cle;       // Command latch
  logic       ale;       // Address latch
  logic       we_p;      // Write strobe, one cycle
  logic       re_p;      // Read strobe, one cycle
  logic [7:0] h_io;      // Host driven byte
  logic       h_io_oe;   // Host drives byte
  logic [7:0] d_io;      // Device driven byte
  logic       d_io_oe;   // Device drives byte
  logic       wp_n;      // Write protect, low protects
  logic       ready_busy_pin; // High when ready
  modport host (output cle, ale, we_p, re_p, h_io, h_io_oe, wp_n,
                input d_io, d_io_oe, ready_busy_pin);
  modport dev  (input cle, ale, we_p, re_p, h_io, h_io_oe, wp_n,
                output d_io, d_io_oe, ready_busy_pin);
endinterface : ncps_if

/* File: design/ncps_pkg.sv */
// Purpose: Shared constants for the cached page-program sequencer pair
// Assumes: One 200 MHz clock shared by both ends
// Notes:   Command codes, status bit positions and timing counts
package ncps_pkg;
  // Command codes on the byte port
  localparam logic [7:0] CMD_DATA_IN    = 8'h80; // First plane data input
  localparam logic [7:0] CMD_DATA_IN2   = 8'h81; // Second plane data input
  localparam logic [7:0] CMD_PLANE_SW   = 8'h11; // Plane switch
  localparam logic [7:0] CMD_CACHE_CONF = 8'h15; // Cache program confirm
  localparam logic [7:0] CMD_FINAL_CONF = 8'h10; // Final program confirm
  localparam logic [7:0] CMD_STATUS     = 8'h70; // Plain status read
  localparam logic [7:0] CMD_MSTATUS    = 8'h71; // Multi-district status
  localparam logic [7:0] CMD_RESET      = 8'hFF; // Reset
  // Status byte bit positions (bit one is index 0)
  localparam int ST_CUR    = 0;  // Current page result
  localparam int ST_PREV   = 1;  // Previous page result
  localparam int ST_D0_P   = 1;  // District 0 primary result
  localparam int ST_D1_P   = 2;  // District 1 primary result
  localparam int ST_D0_S   = 3;  // District 0 secondary result
  localparam int ST_D1_S   = 4;  // District 1 secondary result
  localparam int ST_PB_RDY = 5;  // Page buffer ready
  localparam int ST_DC_RDY = 6;  // Data cache ready
  localparam int ST_WP_N   = 7;  // Not write protected
  // Geometry
  localparam int ADDR_CYCLES      = 5;    // Address bytes per plane
  localparam int PAGE_BITS        = 6;    // In-block page bits
  localparam int BLOCKS_PER_DIST  = 2048; // Blocks in each district
  localparam int PAGES_PER_BLOCK  = 64;   // Pages per block
  localparam int DATA_BYTES       = 8;    // Data bytes per plane (model)
  // Timing, in ns, then in cycles of the 5 ns clock
  localparam int CLK_NS           = 5;
  localparam int XFER_NS          = 100;  // Cache transfer busy time
  localparam int PULSE_NS         = 200;  // One program pulse
  localparam int VERIFY_NS        = 50;   // One verify read
  localparam logic [7:0] XFER_CYC =
    8'((XFER_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PULSE_CYC =
    8'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] VERIFY_CYC =
    8'((VERIFY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] MAX_LOOPS = 4'h4; // Program/verify loop limit
  // Host register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0; // Write: start op
  localparam logic [3:0] REG_STATUS = 4'h1; // Read: host state
  localparam logic [3:0] REG_RESULT = 4'h2; // Read: last status byte
  localparam logic [3:0] REG_IRQ    = 4'h3; // Sticky events, W1C
  localparam logic [3:0] REG_MASK   = 4'h4; // Interrupt mask
  localparam logic [3:0] REG_PAGES  = 4'h5; // Pages per run
  localparam logic [3:0] REG_BLOCK  = 4'h6; // Block pair base
  localparam logic [31:0] RST_ZERO  = 32'h0;
endpackage : ncps_pkg

/* File: verification/nand_cache_program_sequencer_tb.sv */
// Purpose: Runs cached two-district program runs end to end
// Assumes: Register port strobes one cycle, start two; read data next cycle
// Notes:   Each run waits on the sticky done bit, never open-ended
`timescale 1ns/100ps
module nand_cache_program_sequencer_tb;
  logic        ref_clk = 1'b0;  // 200 MHz clock
  logic        rst_n   = 1'b0;  // Async reset
  logic [3:0]  reg_addr = 4'h0; // Register index
  logic [31:0] reg_wdata = 32'h0; // Write data
  logic        reg_wr = 1'b0;   // Write strobe
  logic        reg_rd = 1'b0;   // Read strobe
  logic [31:0] reg_rdata;       // Read data
  logic        irq;             // Interrupt level
  logic [1:0]  fail_inject = 2'h0; // Forced district failures
  logic        prog_active;     // Array programming
  logic [31:0] v;               // Last value read
  int          err_total = 0;   // Mismatches
  int          checked = 0;     // Comparisons
  ncps_if link ();
  ncps_dev ncps_dev_i (.ref_clk(ref_clk), .rst_n(rst_n), .port(link),
    .fail_inject(fail_inject), .prog_active(prog_active));
  ncps_host ncps_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .port(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  ncps_assertions ncps_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .cle(link.cle), .ale(link.ale), .we_p(link.we_p), .re_p(link.re_p),
    .h_io(link.h_io), .h_io_oe(link.h_io_oe), .d_io(link.d_io),
    .d_io_oe(link.d_io_oe), .wp_n(link.wp_n),
    .ready_busy_pin(link.ready_busy_pin));
  // Clock
  always #2.5 ref_clk = ~ref_clk;
  // Verdict, the only exit
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // Compare in four-state so unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Status byte from the district failures of every page
  function automatic logic [31:0] exp_res(input logic [1:0] f);
    return {24'h0, 3'h7, f, f, f[0] | f[1]};
  endfunction : exp_res
  // Start strobe spans two edges: start is sampled on alternate cycles
  task automatic run(input logic [31:0] pg_exp);
    int n;
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ncps_pkg::REG_CTRL;
    reg_wdata <= 32'h1;
    repeat (2) @(posedge ref_clk);
    reg_wr <= 1'b0;
    rd(ncps_pkg::REG_STATUS, v);
    chk(v, 32'h1);
    wr(ncps_pkg::REG_PAGES, 32'h5); // Ignored while busy
    v = 32'h0;
    for (n = 0; n < 20000 && v[0] !== 1'b1; n++)
      rd(ncps_pkg::REG_IRQ, v);
    if (v[0] !== 1'b1)
    begin
      err_total++;
      $display("[ERR] %0t run never finished", $time);
      end_of_test();
    end
    rd(ncps_pkg::REG_PAGES, v);
    chk(v, pg_exp);
    rd(ncps_pkg::REG_STATUS, v);
    chk(v, (pg_exp - 32'h1) << 8);
    chk({31'h0, prog_active}, 32'h0);
  endtask : run
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ncps_pkg::REG_PAGES, v);
    chk(v, 32'h40);
    rd(ncps_pkg::REG_MASK, v);
    chk(v, 32'h0);
    rd(ncps_pkg::REG_IRQ, v);
    chk(v, 32'h0);
    rd(4'hF, v);
    chk(v, 32'h0);
    rd(ncps_pkg::REG_STATUS, v);
    chk(v, 32'h0);
    wr(ncps_pkg::REG_BLOCK, 32'h7);
    rd(ncps_pkg::REG_BLOCK, v);
    chk(v, 32'h6);
    chk({31'h0, irq}, 32'h0);
    // Full 64-page run first, then short runs per failure pattern
    for (int i = 0; i < 4; i++)
    begin
      fail_inject <= 2'(i);
      if (i == 1)
        wr(ncps_pkg::REG_PAGES, 32'h2);
      run(i == 0 ? 32'h40 : 32'h2);
      rd(ncps_pkg::REG_RESULT, v);
      chk(v, exp_res(2'(i)));
      rd(ncps_pkg::REG_IRQ, v);
      chk(v, {30'h0, i != 0, 1'b1});
      chk({31'h0, irq}, 32'h0); // Masked off
      wr(ncps_pkg::REG_MASK, 32'h3);
      repeat (2) @(posedge ref_clk);
      #1 chk({31'h0, irq}, 32'h1);
      wr(ncps_pkg::REG_IRQ, 32'h3);
      rd(ncps_pkg::REG_IRQ, v);
      chk(v, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(ncps_pkg::REG_MASK, 32'h0);
    end
    end_of_test();
  end
endmodule : nand_cache_program_sequencer_tb

/* File: verification/ncps_assertions.sv */
// Purpose: Protocol checks on the flash byte port
// Assumes: One clock, reset async low, host reads only 71h status
// Notes:   Sees interface signals only; no bind
`timescale 1ns/100ps
module ncps_assertions (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_p,
  input wire logic       re_p,
  input wire logic [7:0] h_io,
  input wire logic       h_io_oe,
  input wire logic [7:0] d_io,
  input wire logic       d_io_oe,
  input wire logic       wp_n,
  input wire logic       ready_busy_pin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Confirm codes taken on a write strobe
  wire cache_conf = we_p && cle && (h_io == ncps_pkg::CMD_CACHE_CONF);
  wire final_conf = we_p && cle && (h_io == ncps_pkg::CMD_FINAL_CONF);
  property p_cache_busy; cache_conf |=> !ready_busy_pin; endproperty
  a_cache_busy: assert property (p_cache_busy)
    else $error("Pin ready after cache confirm");
  // Last page: one pulse and one verify at least, so 50 cycles busy
  property p_final_hold;
    final_conf |-> ##1 !ready_busy_pin ##49 !ready_busy_pin;
  endproperty
  a_final_hold: assert property (p_final_hold)
    else $error("Ready too soon after final confirm");
  // Worst case: prior page at loop limit plus last page at loop limit
  property p_final_done; final_conf |-> ##[1:1000] ready_busy_pin;
  endproperty
  a_final_done: assert property (p_final_done)
    else $error("Never ready after final confirm");
  property p_stat_out; re_p |=> d_io_oe; endproperty
  a_stat_out: assert property (p_stat_out)
    else $error("No status byte after read strobe");
  property p_wp_bit; d_io_oe |-> d_io[ncps_pkg::ST_WP_N] == wp_n;
  endproperty
  a_wp_bit: assert property (p_wp_bit)
    else $error("Protect bit wrong");
  property p_or_bit;
    d_io_oe |-> d_io[ncps_pkg::ST_CUR] == (d_io[1] | d_io[2]);
  endproperty
  a_or_bit: assert property (p_or_bit)
    else $error("Combined result bit wrong");
  // Pin follows the cache while caching; the buffer may still program
  property p_rdy_bits;
    d_io_oe && $past(ready_busy_pin) |-> d_io[ncps_pkg::ST_DC_RDY];
  endproperty
  a_rdy_bits: assert property (p_rdy_bits)
    else $error("Ready bits low while pin ready");
  property p_one_strobe; we_p |-> !re_p && !(cle && ale) && h_io_oe;
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("Bad write cycle qualifiers");
  property p_host_waits; we_p |-> ready_busy_pin; endproperty
  a_host_waits: assert property (p_host_waits)
    else $error("Host wrote while busy");
  // Main scenarios
  c_cache: cover property (cache_conf);
  c_final: cover property (final_conf);
  c_fail: cover property (d_io_oe && d_io[0]);
endmodule : ncps_assertions
